//--- verilog/runaway_code_watchdog.sv
// watchdog timer with prescaler, reset pulse and AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1 - 6-bit counter fed by 12-bit prescaler
// R2 - timeout after 2^18-16 or 2^13-16 cycles
// R3 - rate bit one selects short period
// R4 - any service write clears counter, prescaler 12-5
// R5 - service location reads reset vector low byte
// R6 - timeout drives reset pin 32 cycles, sets cause
// R7 - stop instruction clears the prescaler
// R8 - prescaler cleared 4096 cycles after power-up
// R9 - internal reset clears prescaler and counter
// R10 - disable configuration suppresses any timeout reset
// R11 - disable bit one disables, zero enables
// R12 - no processor interrupt, only a reset
// R13 - disabled in monitor mode with high voltage
// R14 - keeps counting during wait mode
// R15 - stop mode gates clock, clears prescaler
// R16 - break in monitor mode disables when bit set
// R17 - software services after reset and around stop
// R18 - software services from main program flow
// R19 - counter steps on selected tap carry, holds when full
module runaway_code_watchdog
    import watchdog_pkg::*;
(
    input  wire logic                  CLK_I,
    input  wire logic                  SRST_I,
    // AXI4-Lite slave
    input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic                  S_AXI_AWVALID_I,
    output logic                       S_AXI_AWREADY_O,
    input  wire logic [AXI_DATA_W-1:0] S_AXI_WDATA_I,
    input  wire logic [3:0]            S_AXI_WSTRB_I,
    input  wire logic                  S_AXI_WVALID_I,
    output logic                       S_AXI_WREADY_O,
    output logic [1:0]                 S_AXI_BRESP_O,
    output logic                       S_AXI_BVALID_O,
    input  wire logic                  S_AXI_BREADY_I,
    input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic                  S_AXI_ARVALID_I,
    output logic                       S_AXI_ARREADY_O,
    output logic [AXI_DATA_W-1:0]      S_AXI_RDATA_O,
    output logic [1:0]                 S_AXI_RRESP_O,
    output logic                       S_AXI_RVALID_O,
    input  wire logic                  S_AXI_RREADY_I,
    // system inputs
    input  wire logic                  STOP_I,
    input  wire logic                  INT_RST_I,
    input  wire logic                  MONITOR_I,
    input  wire logic                  TEST_HV_I,
    input  wire logic                  BREAK_I,
    input  wire logic [7:0]            RESET_VECTOR_LO_I,
    // reset outputs and bus interrupt
    output logic                       WDOG_RESET_O,
    output logic                       RST_N_O,
    output logic                       RST_OE_O,
    output logic                       IRQ_O
);

    // one-hot register select, bit order below
    localparam int SEL_CONTROL = 0;
    localparam int SEL_COUNT   = 1;
    localparam int SEL_STATUS  = 2;
    localparam int SEL_MASK    = 3;
    localparam int SEL_CAUSE   = 4;
    localparam int SEL_SERVICE = 5;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;

    // shared address decode for the read and write paths
    function automatic logic [5:0] decode_sel(input logic [AXI_ADDR_W-1:0] addr);
        logic [5:0] sel;
        sel = 6'h00;
        sel[SEL_CONTROL] = (addr[AXI_ADDR_W-1:2] == ADDR_CONTROL[AXI_ADDR_W-1:2]);
        sel[SEL_COUNT]   = (addr[AXI_ADDR_W-1:2] == ADDR_COUNT[AXI_ADDR_W-1:2]);
        sel[SEL_STATUS]  = (addr[AXI_ADDR_W-1:2] == ADDR_IRQ_STATUS[AXI_ADDR_W-1:2]);
        sel[SEL_MASK]    = (addr[AXI_ADDR_W-1:2] == ADDR_IRQ_MASK[AXI_ADDR_W-1:2]);
        sel[SEL_CAUSE]   = (addr[AXI_ADDR_W-1:2] == ADDR_CAUSE[AXI_ADDR_W-1:2]);
        sel[SEL_SERVICE] = (addr[AXI_ADDR_W-1:2] == ADDR_SERVICE[AXI_ADDR_W-1:2]);
        return sel;
    endfunction

    // prescaler side of the last cycle of the period: tap bits above the low four all ones, low four bits zero
    function automatic logic at_tap_end(input logic [PRESCALER_W-1:0] presc,
                                        input logic                   short_rate);
        logic hit;
        hit = 1'b0;
        if (short_rate)
        begin
            hit = (&presc[SHORT_TAP_MSB:SERVICE_CLR_LSB])
                  && (presc[SERVICE_CLR_LSB-1:0] == '0);
        end
        else
        begin
            hit = (&presc[LONG_TAP_MSB:SERVICE_CLR_LSB])
                  && (presc[SERVICE_CLR_LSB-1:0] == '0);
        end
        return hit;
    endfunction

    // register state
    cfg_s                     cfg;
    evt_s                     irq_status;
    evt_s                     irq_mask;
    logic                     cause_wdog;

    // timer state
    logic [PRESCALER_W-1:0]   prescaler;
    logic [WDOG_W-1:0]        wdog_count;
    logic [PRESCALER_W-1:0]   por_count;
    logic                     por_done;
    logic                     por_clear;
    logic                     pulse_active;
    logic                     internal_clear;
    logic                     disabled;
    logic                     tap_carry;
    logic                     timeout;
    logic                     service;
    evt_s                     events;

    // write channel state
    logic                     aw_held;
    logic [AXI_ADDR_W-1:0]    aw_addr;
    logic                     w_held;
    logic [AXI_DATA_W-1:0]    w_data;
    logic [3:0]               w_strb;
    logic                     wr_fire;
    logic [5:0]               wr_sel;

    // read channel state
    rd_state_e                rd_state;
    logic                     rd_fire;
    logic [5:0]               rd_sel;
    logic                     clr_status;
    logic                     clr_cause;
    logic [AXI_DATA_W-1:0]    next_rdata;
    logic [1:0]               next_rresp;

    // ---- timer core ----

    // power-up settle count, clears the prescaler once at its end
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            por_count <= '0;
            por_done  <= 1'b0;
        end
        else if (!por_done)
        begin
            por_count <= por_count + 1'b1;
            por_done  <= (por_count == PRESCALER_W'(POR_CYCLES - 1));
        end
    end

    assign por_clear = !por_done && (por_count == PRESCALER_W'(POR_CYCLES - 1)); // R8

    // own timeout pulse or an outside internal reset clears the chain
    assign internal_clear = pulse_active || INT_RST_I; // R9

    // disable sources: configuration, monitor high voltage, break in monitor
    assign disabled = cfg.watchdog_disable_cfg // R10 R11
                      || (MONITOR_I && TEST_HV_I) // R13
                      || (MONITOR_I && BREAK_I && cfg.break_watchdog_disable); // R16

    // carry out of the selected prescaler stage
    assign tap_carry = cfg.timeout_rate_select ? (&prescaler[SHORT_TAP_MSB:0]) // R3
                                               : (&prescaler[LONG_TAP_MSB:0]); // R19

    // service write seen at the bus; a service in the last cycle wins
    assign service = wr_fire && wr_sel[SEL_SERVICE]; // R4

    // wait mode has no input here: nothing stops the count
    assign timeout = !disabled && !STOP_I && !service && !internal_clear // R14
                     && (wdog_count == {WDOG_W{1'b1}}) // R19
                     && at_tap_end(prescaler, cfg.timeout_rate_select); // R2

    // free-running prescaler shared with system integration
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || internal_clear || por_clear) // R9 R8
        begin
            prescaler <= '0;
        end
        else if (STOP_I) // R7 R15
        begin
            prescaler <= '0;
        end
        else if (service)
        begin
            prescaler <= {{(PRESCALER_W-SERVICE_CLR_LSB){1'b0}}, // R4
                          prescaler[SERVICE_CLR_LSB-1:0]};
        end
        else
        begin
            prescaler <= prescaler + 1'b1; // R1
        end
    end

    // watchdog counter, frozen in stop since its clock is gated there
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || internal_clear || service || disabled) // R9 R4 R10
        begin
            wdog_count <= '0;
        end
        else if (!STOP_I && tap_carry && (wdog_count != {WDOG_W{1'b1}})) // R15 R19
        begin
            wdog_count <= wdog_count + 1'b1; // R1
        end
    end

    // timeout stretches into the reset pulse; counters stay clear meanwhile
    reset_pulse_gen #(
        .CYCLES   (RST_PULSE_CYCLES)
    ) u_pulse (
        .clk_i    (CLK_I),
        .srst_i   (SRST_I),
        .start_i  (timeout),
        .active_o (pulse_active)
    );

    // watchdog only ever resets; the pin is open drain, pulled low when enabled
    assign WDOG_RESET_O = pulse_active; // R12
    assign RST_N_O      = 1'b0;
    assign RST_OE_O     = pulse_active && cfg.reset_pin_enable; // R6

    // ---- events and interrupt ----

    assign events.timeout  = timeout;
    assign events.serviced = service;

    // sticky status, read clears, a new event in the same cycle wins
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            irq_status <= '0;
        end
        else if (clr_status)
        begin
            irq_status <= events;
        end
        else
        begin
            irq_status <= irq_status | events;
        end
    end

    // reset cause bit, read clears, timeout wins over the clear
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            cause_wdog <= 1'b0;
        end
        else if (timeout)
        begin
            cause_wdog <= 1'b1; // R6
        end
        else if (clr_cause)
        begin
            cause_wdog <= 1'b0;
        end
    end

    // bus-side interrupt, not a processor request of the watchdog
    assign IRQ_O = |(irq_status & irq_mask);

    // ---- AXI4-Lite write path ----

    // address and data are taken independently, held until both are in
    assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
    assign wr_fire         = aw_held && w_held && !S_AXI_BVALID_O;
    assign wr_sel          = decode_sel(aw_addr);

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
        begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
        end
        else if (S_AXI_WVALID_I && S_AXI_WREADY_O)
        begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end
        else if (wr_fire)
        begin
            w_held <= 1'b0;
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (|wr_sel) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY_I)
        begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // control and mask live in byte lane 0; read-only words ignore writes
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            cfg      <= cfg_s'(CTL_RESET);
            irq_mask <= evt_s'(IRQ_MASK_RESET);
        end
        else if (wr_fire && w_strb[0])
        begin
            if (wr_sel[SEL_CONTROL])
            begin
                cfg.timeout_rate_select    <= w_data[CTL_RATE_BIT]; // R3
                cfg.watchdog_disable_cfg   <= w_data[CTL_DISABLE_BIT]; // R11
                cfg.reset_pin_enable       <= w_data[CTL_PIN_EN_BIT];
                cfg.break_watchdog_disable <= w_data[CTL_BRK_DIS_BIT];
            end
            if (wr_sel[SEL_MASK])
            begin
                irq_mask <= w_data[1:0];
            end
        end
    end

    // ---- AXI4-Lite read path ----

    assign S_AXI_ARREADY_O = (rd_state == RD_IDLE);
    assign rd_fire         = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    assign rd_sel          = decode_sel(S_AXI_ARADDR_I);
    assign clr_status      = rd_fire && rd_sel[SEL_STATUS];
    assign clr_cause       = rd_fire && rd_sel[SEL_CAUSE];

    // read data mux; the service word never exposes watchdog state
    always_comb
    begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        if (rd_sel[SEL_CONTROL])
        begin
            next_rdata[CTL_BRK_DIS_BIT:CTL_RATE_BIT] = cfg;
        end
        else if (rd_sel[SEL_COUNT])
        begin
            next_rdata[CNT_WDOG_LSB +: WDOG_W]       = wdog_count;
            next_rdata[CNT_PRESC_LSB +: PRESCALER_W] = prescaler;
            next_rdata[CNT_ACTIVE_BIT]               = pulse_active;
        end
        else if (rd_sel[SEL_STATUS])
        begin
            next_rdata[1:0] = irq_status;
        end
        else if (rd_sel[SEL_MASK])
        begin
            next_rdata[1:0] = irq_mask;
        end
        else if (rd_sel[SEL_CAUSE])
        begin
            next_rdata[CAUSE_WDOG_BIT] = cause_wdog;
        end
        else if (rd_sel[SEL_SERVICE])
        begin
            next_rdata[7:0] = RESET_VECTOR_LO_I; // R5
        end
        else
        begin
            next_rresp = RESP_SLVERR;
        end
    end

    // single outstanding read, data registered at the address handshake
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            rd_state <= RD_IDLE;
        end
        else
        begin
            case (rd_state)
                RD_IDLE:
                begin
                    if (rd_fire)
                    begin
                        rd_state <= RD_RESP;
                    end
                end
                RD_RESP:
                begin
                    if (S_AXI_RREADY_I)
                    begin
                        rd_state <= RD_IDLE;
                    end
                end
                default:
                begin
                    rd_state <= RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            S_AXI_RDATA_O <= next_rdata;
            S_AXI_RRESP_O <= next_rresp;
        end
    end

    assign S_AXI_RVALID_O = (rd_state == RD_RESP);

endmodule // runaway_code_watchdog

`default_nettype wire

//--- verilog/watchdog_pkg.sv
// constants, register map and carrier types shared by the watchdog design
package watchdog_pkg;

    // bus geometry
    localparam int          AXI_ADDR_W      = 18;
    localparam int          AXI_DATA_W      = 32;

    // register index of the service location, byte address is four times it
    localparam logic [15:0] SERVICE_INDEX   = 16'hffff;
    localparam logic [17:0] ADDR_SERVICE    = {SERVICE_INDEX, 2'b00};
    localparam logic [17:0] ADDR_CONTROL    = 18'h00000;
    localparam logic [17:0] ADDR_COUNT      = 18'h00004;
    localparam logic [17:0] ADDR_IRQ_STATUS = 18'h00008;
    localparam logic [17:0] ADDR_IRQ_MASK   = 18'h0000c;
    localparam logic [17:0] ADDR_CAUSE      = 18'h00010;

    // control register field positions
    localparam int          CTL_RATE_BIT    = 0;
    localparam int          CTL_DISABLE_BIT = 1;
    localparam int          CTL_PIN_EN_BIT  = 2;
    localparam int          CTL_BRK_DIS_BIT = 3;

    // count register field positions
    localparam int          CNT_WDOG_LSB    = 0;
    localparam int          CNT_PRESC_LSB   = 8;
    localparam int          CNT_ACTIVE_BIT  = 24;

    // cause register field position
    localparam int          CAUSE_WDOG_BIT  = 0;

    // counter geometry and taps
    localparam int          PRESCALER_W     = 12;
    localparam int          WDOG_W          = 6;
    localparam int          LONG_TAP_MSB    = 11;
    localparam int          SHORT_TAP_MSB   = 6;
    localparam int          SERVICE_CLR_LSB = 4;

    // cycle counts on the oscillator clock
    localparam int          RST_PULSE_CYCLES = 32;
    localparam int          POR_CYCLES       = 4096;

    // reset values
    localparam logic [3:0]  CTL_RESET       = 4'h0;
    localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;

    // bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // configuration bits held in the control register
    typedef struct packed {
        logic break_watchdog_disable;
        logic reset_pin_enable;
        logic watchdog_disable_cfg;
        logic timeout_rate_select;
    } cfg_s;

    // events that feed the sticky interrupt status
    typedef struct packed {
        logic serviced;
        logic timeout;
    } evt_s;

endpackage

//--- verilog/reset_pulse_gen.sv
// fixed-length reset pulse stretcher for the watchdog timeout
`timescale 1ns/10ps
`default_nettype none

module reset_pulse_gen
    import watchdog_pkg::*;
#(
    parameter int CYCLES = RST_PULSE_CYCLES
)
(
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic start_i,
    output logic      active_o
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] remaining;

    // load on start, count down to zero; a new start restarts the pulse
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            remaining <= '0;
        end
        else if (start_i)
        begin
            remaining <= CW'(CYCLES);
        end
        else if (remaining != '0)
        begin
            remaining <= remaining - 1'b1;
        end
    end

    // registered flag so the pulse is exactly CYCLES edges long
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            active_o <= 1'b0;
        end
        else if (start_i)
        begin
            active_o <= 1'b1;
        end
        else if (remaining == CW'(1))
        begin
            active_o <= 1'b0;
        end
    end

endmodule // reset_pulse_gen

`default_nettype wire

//--- tb/watchdog_properties.sv
// port-level assertion checker for the watchdog timer
`timescale 1ns/10ps
`default_nettype none
module watchdog_properties
    import watchdog_pkg::*;
(
    input  wire logic                  CLK_I,
    input  wire logic                  SRST_I,
    input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic                  S_AXI_ARVALID_I,
    input  wire logic                  S_AXI_ARREADY_O,
    input  wire logic [AXI_DATA_W-1:0] S_AXI_RDATA_O,
    input  wire logic [1:0]            S_AXI_RRESP_O,
    input  wire logic                  S_AXI_RVALID_O,
    input  wire logic                  S_AXI_RREADY_I,
    input  wire logic                  S_AXI_BVALID_O,
    input  wire logic                  S_AXI_BREADY_I,
    input  wire logic                  STOP_I,
    input  wire logic                  INT_RST_I,
    input  wire logic                  MONITOR_I,
    input  wire logic                  TEST_HV_I,
    input  wire logic [7:0]            RESET_VECTOR_LO_I,
    input  wire logic                  WDOG_RESET_O,
    input  wire logic                  RST_N_O,
    input  wire logic                  RST_OE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    // cycles the reset request has stood, zero while idle
    logic [7:0] high_count;
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || !WDOG_RESET_O)
            high_count <= 8'h00;
        else
            high_count <= high_count + 8'h01;
    end
    // a reset cut short by the bus reset is not a short pulse
    a_pulse_length: assert property (!$past(SRST_I) && $fell(WDOG_RESET_O) |-> high_count == 8'h20)
        else $error("reset pulse length wrong");
    a_pulse_bound: assert property (high_count <= 8'h20)
        else $error("reset pulse too long");
    a_pin_follow: assert property (RST_OE_O |-> WDOG_RESET_O)
        else $error("reset pin driven without timeout");
    a_pin_level: assert property (RST_N_O == 1'b0)
        else $error("reset pin not pulled low");
    a_stop_quiet: assert property (STOP_I |=> !$rose(WDOG_RESET_O))
        else $error("timeout during stop");
    a_intrst_quiet: assert property (INT_RST_I |=> !$rose(WDOG_RESET_O))
        else $error("timeout during internal reset");
    a_monitor_quiet: assert property (MONITOR_I && TEST_HV_I |=> !$rose(WDOG_RESET_O))
        else $error("timeout in monitor mode");
    a_vector_read: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        && S_AXI_ARADDR_I == ADDR_SERVICE |=> S_AXI_RVALID_O
        && S_AXI_RDATA_O == {24'h000000, $past(RESET_VECTOR_LO_I)})
        else $error("service read not the vector");
    a_read_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
        S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
        else $error("read answer dropped early");
    a_write_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
        else $error("write answer dropped early");
endmodule // watchdog_properties
bind runaway_code_watchdog watchdog_properties watchdog_properties_inst (
    .CLK_I, .SRST_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
    .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
    .S_AXI_BVALID_O, .S_AXI_BREADY_I, .STOP_I, .INT_RST_I, .MONITOR_I, .TEST_HV_I,
    .RESET_VECTOR_LO_I, .WDOG_RESET_O, .RST_N_O, .RST_OE_O);
`default_nettype wire

//--- tb/test_runaway_code_watchdog.sv
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
`default_nettype none
module test_runaway_code_watchdog
    import watchdog_pkg::*;
;
    logic        clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
    logic        arv = 1'b0, rrdy = 1'b0, stop = 1'b0, irst = 1'b0;
    logic        mon = 1'b0, hv = 1'b0, brk = 1'b0;
    logic [17:0] awa = 18'h00000, ara = 18'h00000;
    logic [31:0] wd = 32'h00000000, rd, data, seed = 32'hb256;
    logic [7:0]  vec = 8'h00;
    logic [1:0]  bresp, rresp, resp;
    logic        awr, wr, arr, rv, bv, wdog, rstn, oe, irq, oe_seen;
    logic [8:0]  c;
    int          num_errors = 0, checks = 0, cycle = 0, rise_at, high_len;
    // {control[3:0], stop, internal reset, monitor, test voltage, break}
    localparam logic [8:0] CASES [10] = '{9'h0a0, 9'h0e0, 9'h0b0, 9'h0a8, 9'h0a6,
                                          9'h1a5, 9'h0a5, 9'h0a4, 9'h020, 9'h1a1};
    runaway_code_watchdog runaway_code_watchdog_inst (
        .CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(ara),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy),
        .STOP_I(stop), .INT_RST_I(irst), .MONITOR_I(mon), .TEST_HV_I(hv),
        .BREAK_I(brk), .RESET_VECTOR_LO_I(vec), .WDOG_RESET_O(wdog),
        .RST_N_O(rstn), .RST_OE_O(oe), .IRQ_O(irq));
    always #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // a timeout is due unless one of the disabling conditions holds
    function automatic logic will_fire(input logic [8:0] v);
        return !(v[6] || v[4] || v[3] || (v[2] && (v[1] || (v[0] && v[8]))));
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // readies are sampled mid-cycle, where they already hold their edge value
    task automatic bus_write(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        @(posedge clk);
        {awa, wd, awv, wv, brdy} <= {a, d, 3'b111};
        do
        begin
            @(negedge clk);
            {aw_hit, w_hit, b_hit, r} = {awv && awr, wv && wr, bv, bresp};
            @(posedge clk);
            {awv, wv} <= {awv && !aw_hit, wv && !w_hit};
        end
        while (!b_hit);
        brdy <= 1'b0;
    endtask
    task automatic bus_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit, hit;
        @(posedge clk);
        {ara, arv, rrdy} <= {a, 2'b11};
        do
        begin
            @(negedge clk);
            {ar_hit, hit, d, r} = {arv && arr, rv, rd, rresp};
            @(posedge clk);
            arv <= arv && !ar_hit;
        end
        while (!hit);
        rrdy <= 1'b0;
    endtask
    // watch the reset request: first rise, length and pin drive
    task automatic watch(input int limit);
        rise_at = -1;
        high_len = 0;
        oe_seen = 1'b0;
        for (int i = 0; i < limit; i++)
        begin
            @(negedge clk);
            if (wdog === 1'b1 && rise_at < 0)
                rise_at = i;
            if (wdog === 1'b1)
                high_len++;
            if (oe === 1'b1)
                oe_seen = 1'b1;
        end
    endtask
    // hang guard, well above the ten timeout periods
    always @(posedge clk)
    begin
        cycle <= cycle + 1;
        if (cycle == 95000)
        begin
            num_errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        bus_read(ADDR_CONTROL, data, resp);
        check("control reset", 32'(CTL_RESET), data);
        bus_read(ADDR_IRQ_MASK, data, resp);
        check("mask reset", 32'(IRQ_MASK_RESET), data);
        bus_read(18'h00100, data, resp);
        check("unmapped read", 32'(RESP_SLVERR), {data[29:0], resp});
        bus_write(18'h00100, 32'h0000000f, resp);
        check("unmapped write", 32'(RESP_SLVERR), 32'(resp));
        repeat (3)
        begin
            seed = xs(seed);
            vec <= seed[7:0];
            bus_read(ADDR_SERVICE, data, resp);
            check("vector", 32'(seed[7:0]), data);
        end
        bus_write(ADDR_IRQ_MASK, 32'h00000001, resp);
        // let the power-up prescaler clear pass before timing periods
        repeat (4200) @(posedge clk);
        foreach (CASES[k])
        begin
            c = CASES[k];
            bus_write(ADDR_CONTROL, 32'(c[8:5]), resp);
            bus_read(ADDR_CONTROL, data, resp);
            check("control", 32'(c[8:5]), data);
            bus_read(ADDR_IRQ_STATUS, data, resp);
            @(posedge clk);
            stop <= c[4];
            irst <= c[3];
            mon <= c[2];
            hv <= c[1];
            brk <= c[0];
            seed = xs(seed);
            bus_write(ADDR_SERVICE, seed, resp);
            watch(8300);
            check("fired", 32'(will_fire(c)), 32'(rise_at >= 0));
            if (will_fire(c))
            begin
                check("period", 32'h1, 32'(rise_at >= 8150 && rise_at <= 8180));
                check("pulse", 32'h20, high_len);
            end
            check("pin", 32'(will_fire(c) && c[7]), 32'(oe_seen));
            check("irq", 32'(will_fire(c)), 32'(irq));
            bus_read(ADDR_IRQ_STATUS, data, resp);
            check("status", 32'(will_fire(c)), 32'(data[0]));
            @(negedge clk);
            check("irq clear", 32'h0, 32'(irq));
            bus_read(ADDR_CAUSE, data, resp);
            check("cause", 32'(will_fire(c)), 32'(data[CAUSE_WDOG_BIT]));
            bus_read(ADDR_CAUSE, data, resp);
            check("cause clear", 32'h0, 32'(data[CAUSE_WDOG_BIT]));
        end
        stop_test();
    end
endmodule // test_runaway_code_watchdog
`default_nettype wire
